/* File: bbr_params.svh */
// What this block does
// - The primary IO window register reads its space bit as one (IO).
// - The primary IO window is 256 bytes; its base is bits 31:8, reset 0.
// - Window 1 size and memory-or-IO type come from its setup register.
// - Setup registers load at init from serial memory, SMBus or a CPU.
// - Writing zero to setup bit 31 disables the matching window register.
// - Window 1 spans 4KB to 2GB as memory and 64B to 256B as IO.
// - Window 1 forwarded accesses are translated by its translated base.
// - A memory base bit is writable only where the setup bit is one; IO base bits 31:8 always are.
// - Bits 2:1 give the address type, 00 32-bit, 01 64-bit, reset 00.
// - Bit 3 shows prefetchable; bits 11:4 read zero except IO base bits 7:6.
// - Window 2 base register sits at offset 1Ch with the same fields.
// - Window 2 size and address type come from its own setup register; it maps memory only.
`ifndef BBR_PARAMS_SVH
`define BBR_PARAMS_SVH

`define BBR_AW 12
`define BBR_OFF_PIO 12'h014
`define BBR_OFF_WIN1 12'h018
`define BBR_OFF_WIN2 12'h01C
`define BBR_OFF_XLAT1 12'h0A8
`define BBR_OFF_SETUP1 12'h0AC
`define BBR_OFF_XLAT2 12'h108
`define BBR_OFF_SETUP2 12'h10C

`define BBR_SPACE_BIT 0
`define BBR_TYPE_LSB 1
`define BBR_TYPE_MSB 2
`define BBR_PREF_BIT 3
`define BBR_IO_SZ_LSB 6
`define BBR_IO_SZ_MSB 7
`define BBR_PIO_BASE_LSB 8
`define BBR_MEM_BASE_LSB 12
`define BBR_EN_BIT 31

`define BBR_TYPE_32 2'h0
`define BBR_TYPE_64 2'h1
`define BBR_PIO_SPACE 1'h1
`define BBR_PIO_BASE_RST 24'h000000
`define BBR_BASE_RST 32'h00000000
`define BBR_SETUP_RST 32'h00000000
`define BBR_XLAT_RST 32'h00000000

`define BBR_HSIZE_BYTE 3'h0
`define BBR_HSIZE_HALF 3'h1

`endif

/* File: bbr_pkg.sv */
package bbr_pkg;

  // one setup load from the init sources (serial memory, smbus, local cpu)
  typedef struct packed {
    logic vld;
    logic sel;
    logic [31:0] data;
  } bbr_init_t;

  typedef struct packed {
    logic hit;
    logic [31:0] addr;
  } bbr_fwd_t;

  typedef struct packed {
    logic vld;
    logic wr;
    logic [11:0] addr;
    logic [3:0] be;
  } bbr_aph_t;

endpackage : bbr_pkg

/* File: bbr_top.sv */
`timescale 1ns/1ns
`include "bbr_params.svh"

module bbr_top (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic [2:0] i_hsize,
  input wire logic [31:0] i_hwdata,
  input wire logic i_hready,
  output logic [31:0] o_hrdata,
  output logic o_hreadyout,
  output logic o_hresp,
  input wire bbr_pkg::bbr_init_t i_init,
  input wire logic [31:0] i_fwd_addr,
  input wire logic [31:0] i_io_addr,
  output bbr_pkg::bbr_fwd_t o_fwd1,
  output bbr_pkg::bbr_fwd_t o_fwd2,
  output logic o_pio_hit
);
  import bbr_pkg::*;

  // byte lanes of a transfer from its size and low address bits
  function automatic logic [3:0] lanes(input logic [2:0] size,
                                       input logic [1:0] a);
    logic [3:0] be;
    be = 4'hF;
    if (size == `BBR_HSIZE_BYTE)
      be = 4'h1 << a;
    else if (size == `BBR_HSIZE_HALF)
      be = a[1] ? 4'hC : 4'h3;
    return be;
  endfunction : lanes

  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}};
    return (old & ~m) | (wd & m);
  endfunction : merge

  bbr_aph_t aph_r;
  bbr_aph_t aph_nxt;
  logic [31:0] rdata_r;
  logic [31:0] rdata_nxt;
  logic hready_r;
  logic hresp_r;

  logic [31:0] setup1_r;
  logic [31:0] setup1_nxt;
  logic [31:0] setup2_r;
  logic [31:0] setup2_nxt;
  logic [31:0] xlat1_r;
  logic [31:0] xlat1_nxt;
  logic [31:0] xlat2_r;
  logic [31:0] xlat2_nxt;
  logic [23:0] pio_base_r;
  logic [23:0] pio_base_nxt;
  logic pio_hit_r;
  logic pio_hit_nxt;
  logic [31:0] pio_wr;

  logic wr_pio;
  logic wr_win1;
  logic wr_win2;
  logic wr_setup1;
  logic wr_setup2;
  logic wr_xlat1;
  logic wr_xlat2;
  logic [31:0] win1_rd;
  logic [31:0] win2_rd;
  logic [31:0] pio_rd;

  // address phase capture; data lands one cycle later
  always_comb
  begin
    aph_nxt.vld = i_hsel & i_hready & i_htrans[1];
    aph_nxt.wr = i_hwrite;
    aph_nxt.addr = i_haddr[`BBR_AW-1:0];
    aph_nxt.be = lanes(i_hsize, i_haddr[1:0]);
    if (!aph_nxt.vld)
      aph_nxt = '0;
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
      aph_r <= '0;
    else
      aph_r <= aph_nxt;
  end

  // write strobes in the data phase; unmapped offsets get none
  always_comb
  begin
    wr_pio = 1'b0;
    wr_win1 = 1'b0;
    wr_win2 = 1'b0;
    wr_setup1 = 1'b0;
    wr_setup2 = 1'b0;
    wr_xlat1 = 1'b0;
    wr_xlat2 = 1'b0;
    if (aph_r.vld && aph_r.wr)
    begin
      case (aph_r.addr)
        `BBR_OFF_PIO: wr_pio = 1'b1;
        `BBR_OFF_WIN1: wr_win1 = 1'b1;
        `BBR_OFF_WIN2: wr_win2 = 1'b1;
        `BBR_OFF_SETUP1: wr_setup1 = 1'b1;
        `BBR_OFF_SETUP2: wr_setup2 = 1'b1;
        `BBR_OFF_XLAT1: wr_xlat1 = 1'b1;
        `BBR_OFF_XLAT2: wr_xlat2 = 1'b1;
        default: wr_pio = 1'b0;
      endcase
    end
  end

  // setup and translation registers; an init load beats a bus write
  always_comb
  begin
    setup1_nxt = setup1_r;
    setup2_nxt = setup2_r;
    xlat1_nxt = xlat1_r;
    xlat2_nxt = xlat2_r;
    if (wr_setup1)
      setup1_nxt = merge(setup1_r, i_hwdata, aph_r.be);
    if (wr_setup2)
      setup2_nxt = merge(setup2_r, i_hwdata, aph_r.be);
    if (i_init.vld && !i_init.sel)
      setup1_nxt = i_init.data;
    if (i_init.vld && i_init.sel)
      setup2_nxt = i_init.data;
    // bits 11:4 of a setup word carry no meaning and read zero,
    // except the io size bits of window 1
    setup1_nxt[5:4] = 2'h0;
    setup1_nxt[11:8] = 4'h0;
    setup2_nxt[11:4] = 8'h00;
    // window 2 is memory only
    setup2_nxt[`BBR_SPACE_BIT] = 1'b0;
    if (wr_xlat1)
      xlat1_nxt = merge(xlat1_r, i_hwdata, aph_r.be);
    if (wr_xlat2)
      xlat2_nxt = merge(xlat2_r, i_hwdata, aph_r.be);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      setup1_r <= `BBR_SETUP_RST;
      setup2_r <= `BBR_SETUP_RST;
      xlat1_r <= `BBR_XLAT_RST;
      xlat2_r <= `BBR_XLAT_RST;
    end
    else
    begin
      setup1_r <= setup1_nxt;
      setup2_r <= setup2_nxt;
      xlat1_r <= xlat1_nxt;
      xlat2_r <= xlat2_nxt;
    end
  end

  // primary io window: fixed 256-byte size, base always writable
  always_comb
  begin
    pio_base_nxt = pio_base_r;
    pio_wr = merge({pio_base_r, 8'h00}, i_hwdata, aph_r.be);
    if (wr_pio)
      pio_base_nxt = pio_wr[31:`BBR_PIO_BASE_LSB];
    pio_rd = {pio_base_nxt, 7'h00, `BBR_PIO_SPACE};
    pio_hit_nxt = (i_io_addr[31:`BBR_PIO_BASE_LSB] == pio_base_r);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      pio_base_r <= `BBR_PIO_BASE_RST;
      pio_hit_r <= 1'b0;
    end
    else
    begin
      pio_base_r <= pio_base_nxt;
      pio_hit_r <= pio_hit_nxt;
    end
  end

  // window 1 follows setup1 and may map io or memory
  bbr_win #(
    .IO_OK(1'b1)
  ) u_win1 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_setup(setup1_nxt),
    .i_xlat(xlat1_r),
    .i_we(wr_win1),
    .i_wdata(i_hwdata),
    .i_be(aph_r.be),
    .i_fwd_addr(i_fwd_addr),
    .o_rd(win1_rd),
    .o_fwd(o_fwd1)
  );

  // window 2 follows setup2 and maps memory only
  bbr_win #(
    .IO_OK(1'b0)
  ) u_win2 (
    .i_clk(i_clk),
    .i_rst(i_rst),
    .i_setup(setup2_nxt),
    .i_xlat(xlat2_r),
    .i_we(wr_win2),
    .i_wdata(i_hwdata),
    .i_be(aph_r.be),
    .i_fwd_addr(i_fwd_addr),
    .o_rd(win2_rd),
    .o_fwd(o_fwd2)
  );

  // read data is taken from the next-state view so that a read right
  // behind a write to the same register sees the new value without
  // a wait state
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    if (aph_nxt.vld && !aph_nxt.wr)
    begin
      case (aph_nxt.addr)
        `BBR_OFF_PIO: rdata_nxt = pio_rd;
        `BBR_OFF_WIN1: rdata_nxt = win1_rd;
        `BBR_OFF_WIN2: rdata_nxt = win2_rd;
        `BBR_OFF_SETUP1: rdata_nxt = setup1_nxt;
        `BBR_OFF_SETUP2: rdata_nxt = setup2_nxt;
        `BBR_OFF_XLAT1: rdata_nxt = xlat1_nxt;
        `BBR_OFF_XLAT2: rdata_nxt = xlat2_nxt;
        default: rdata_nxt = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      rdata_r <= 32'h00000000;
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
    end
    else
    begin
      rdata_r <= rdata_nxt;
      // every transfer completes in one data-phase cycle, always okay
      hready_r <= 1'b1;
      hresp_r <= 1'b0;
    end
  end

  assign o_hrdata = rdata_r;
  assign o_hreadyout = hready_r;
  assign o_hresp = hresp_r;
  assign o_pio_hit = pio_hit_r;

endmodule : bbr_top

/* File: bbr_top_assertions.sv */
`timescale 1ns/1ns
module bbr_top_assertions (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_hsel,
  input wire logic [31:0] i_haddr,
  input wire logic [1:0] i_htrans,
  input wire logic i_hwrite,
  input wire logic i_hready,
  input wire logic [31:0] o_hrdata,
  input wire logic o_hresp,
  input wire bbr_pkg::bbr_fwd_t o_fwd1,
  input wire bbr_pkg::bbr_fwd_t o_fwd2,
  input wire logic o_pio_hit
);
  import bbr_pkg::*;
  logic rd;
  logic win;
  logic mapped;
  logic [11:0] a;
  assign a = i_haddr[11:0];
  assign rd = i_hsel && i_hready && i_htrans[1] && !i_hwrite;
  assign win = rd && (a == 12'h018 || a == 12'h01C);
  assign mapped = a inside {12'h014, 12'h018, 12'h01C, 12'h0A8, 12'h0AC,
    12'h108, 12'h10C};
  default clocking @(posedge i_clk); endclocking
  default disable iff (i_rst);
  a_resp_okay: assert property (o_hresp == 1'b0)
    else $error("error response seen");
  a_pio_space: assert property (rd && a == 12'h014 |=>
    o_hrdata[7:0] == 8'h01) else $error("io window low byte wrong");
  a_win_resvd: assert property (win |=> o_hrdata[11:8] == 4'h0 &&
    o_hrdata[5:4] == 2'h0) else $error("reserved bits set");
  a_type_legal: assert property (win |=> !o_hrdata[2])
    else $error("reserved address type read");
  a_win2_mem: assert property (rd && a == 12'h01C |=> !o_hrdata[0])
    else $error("window 2 reads as io");
  a_unmap_zero: assert property (rd && !mapped |=> o_hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_idle_zero: assert property (!rd |=> o_hrdata == 32'h0)
    else $error("read data outside data phase");
  a_reset_quiet: assert property (disable iff (1'b0) i_rst |->
    !o_pio_hit && !o_fwd1.hit && !o_fwd2.hit && o_hrdata == 32'h0)
    else $error("outputs active in reset");
endmodule : bbr_top_assertions

bind bbr_top bbr_top_assertions u_chk (.i_clk, .i_rst, .i_hsel, .i_haddr,
  .i_htrans, .i_hwrite, .i_hready, .o_hrdata, .o_hresp, .o_fwd1, .o_fwd2,
  .o_pio_hit);

/* File: bbr_top_test.sv */
`timescale 1ns/1ns
module bbr_top_test;
  import bbr_pkg::*;
  logic i_clk = 1'b0;
  logic i_rst = 1'b0;
  logic i_hsel = 1'b0;
  logic [31:0] i_haddr = 32'h0;
  logic [1:0] i_htrans = 2'h0;
  logic i_hwrite = 1'b0;
  logic [2:0] i_hsize = 3'h2;
  logic [31:0] i_hwdata = 32'h0;
  bbr_init_t i_init = '0;
  logic [31:0] i_fwd_addr = 32'h0;
  logic [31:0] i_io_addr = 32'h0;
  logic [31:0] o_hrdata;
  logic o_hreadyout;
  logic o_hresp;
  logic o_pio_hit;
  bbr_fwd_t o_fwd1;
  bbr_fwd_t o_fwd2;
  bbr_fwd_t f1;
  bbr_fwd_t f2;
  logic rsp_q;
  logic ph;
  logic [31:0] rd_q;
  logic rdy_q;
  int num_errors = 0;
  int n_tests = 0;
  always #50 i_clk = ~i_clk;
  // sample a half cycle early so the edge itself never races the design
  always @(negedge i_clk)
  begin
    rd_q = o_hrdata;
    rdy_q = o_hreadyout;
    rsp_q = o_hresp;
  end
  bbr_top uut (.i_clk, .i_rst, .i_hsel, .i_haddr, .i_htrans, .i_hwrite,
    .i_hsize, .i_hwdata, .i_hready(o_hreadyout), .o_hrdata, .o_hreadyout,
    .o_hresp, .i_init, .i_fwd_addr, .i_io_addr, .o_fwd1, .o_fwd2,
    .o_pio_hit);
  task give_verdict;
    $display("checks %0d mismatches %0d", n_tests, num_errors);
    if (num_errors == 0 && n_tests > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict
  task check(input string nm, input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      num_errors++;
      $display("CHECK FAILED %s exp %h got %h", nm, exp, got);
    end
  endtask : check
  task wait_rdy;
    int k;
    k = 0;
    do
    begin
      @(posedge i_clk);
      k++;
    end
    while (rdy_q !== 1'b1 && k < 20);
    if (rdy_q !== 1'b1)
    begin
      num_errors++;
      give_verdict;
    end
  endtask : wait_rdy
  task bus(input logic w, input logic [11:0] a, input logic [31:0] wd,
    output logic [31:0] rd);
    i_hsel <= 1'b1;
    i_htrans <= 2'h2;
    i_haddr <= {20'h0, a};
    i_hwrite <= w;
    wait_rdy;
    i_htrans <= 2'h0;
    i_hwdata <= wd;
    wait_rdy;
    rd = rd_q;
  endtask : bus
  task wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] v;
    bus(1'b1, a, d, v);
  endtask : wr
  task rchk(input string nm, input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] v;
    bus(1'b0, a, 32'h0, v);
    check(nm, v, exp);
    check({nm, " resp"}, 32'(rsp_q), 32'h0);
  endtask : rchk
  task init_load(input logic s, input logic [31:0] d);
    i_init <= '{vld: 1'b1, sel: s, data: d};
    @(posedge i_clk);
    i_init <= '0;
  endtask : init_load
  task dec(input logic [31:0] fa, input logic [31:0] ia);
    i_fwd_addr <= fa;
    i_io_addr <= ia;
    @(posedge i_clk);
    @(negedge i_clk);
    f1 = o_fwd1;
    f2 = o_fwd2;
    ph = o_pio_hit;
    @(posedge i_clk);
  endtask : dec
  task t_reset;
    rchk("pio rst", 12'h014, 32'h00000001);
    rchk("w1 rst", 12'h018, 32'h0);
    rchk("w2 rst", 12'h01C, 32'h0);
  endtask : t_reset
  task t_pio;
    wr(12'h014, 32'hFFFFFFFF);
    rchk("pio rw", 12'h014, 32'hFFFFFF01);
    dec(32'h0, 32'hFFFFFF42);
    check("pio hit", 32'(ph), 32'h1);
    dec(32'h0, 32'hFFFFFE42);
    check("pio miss", 32'(ph), 32'h0);
  endtask : t_pio
  task t_mem;
    wr(12'h0AC, 32'hFFFFF00A);
    wr(12'h018, 32'hFFFFFFFF);
    rchk("w1 mem", 12'h018, 32'hFFFFF00A);
    wr(12'h0AC, 32'hFFFF0000);
    rchk("w1 mask", 12'h018, 32'hFFFF0000);
    wr(12'h0A8, 32'h55550000);
    dec(32'hFFFF1234, 32'h0);
    check("w1 hit", 32'(f1.hit), 32'h1);
    check("w1 xlat", f1.addr, 32'h55551234);
    wr(12'h0AC, 32'h7FFF0000);
    rchk("w1 off", 12'h018, 32'h0);
    dec(32'h00001234, 32'h0);
    check("w1 off hit", 32'(f1.hit), 32'h0);
  endtask : t_mem
  task t_io;
    init_load(1'b0, 32'h800000C1);
    rchk("setup1", 12'h0AC, 32'h800000C1);
    wr(12'h018, 32'hFFFFFFFF);
    rchk("w1 io", 12'h018, 32'hFFFFF0C1);
  endtask : t_io
  task t_win2;
    init_load(1'b1, 32'hFFFFF009);
    wr(12'h01C, 32'hFFFFFFFF);
    rchk("w2 mem", 12'h01C, 32'hFFFFF008);
    wr(12'h10C, 32'hFFFFF004);
    rchk("w2 type", 12'h01C, 32'hFFFFF000);
    wr(12'h108, 32'h12340ABC);
    dec(32'hFFFFF123, 32'h0);
    check("w2 hit", 32'(f2.hit), 32'h1);
    check("w2 xlat", f2.addr, 32'h12340123);
    dec(32'h7FFFF123, 32'h0);
    check("w2 miss", 32'(f2.hit), 32'h0);
  endtask : t_win2
  task t_unmap;
    wr(12'h020, 32'hFFFFFFFF);
    rchk("unmapped", 12'h020, 32'h0);
  endtask : t_unmap
  initial
  begin
    // raised by a nonblocking write at time zero so the reset edge reaches every flop
    i_rst <= 1'b1;
    repeat (8) @(posedge i_clk);
    i_rst <= 1'b0;
    t_reset;
    t_pio;
    t_mem;
    t_io;
    t_win2;
    t_unmap;
    give_verdict;
  end
endmodule : bbr_top_test

/* File: bbr_win.sv */
`timescale 1ns/1ns
`include "bbr_params.svh"

module bbr_win #(
  parameter logic IO_OK = 1'b1
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic [31:0] i_setup,
  input wire logic [31:0] i_xlat,
  input wire logic i_we,
  input wire logic [31:0] i_wdata,
  input wire logic [3:0] i_be,
  input wire logic [31:0] i_fwd_addr,
  output logic [31:0] o_rd,
  output bbr_pkg::bbr_fwd_t o_fwd
);
  import bbr_pkg::*;

  logic en;
  logic io;
  logic [1:0] atype;
  logic [31:0] mask;
  logic [31:0] bemask;
  logic [31:0] base_r;
  logic [31:0] base_nxt;
  bbr_fwd_t fwd_r;
  bbr_fwd_t fwd_nxt;

  always_comb
  begin
    en = i_setup[`BBR_EN_BIT];
    io = IO_OK & i_setup[`BBR_SPACE_BIT];
    atype = `BBR_TYPE_32;
    // reserved type codes are shown as 32-bit rather than echoed
    if (i_setup[`BBR_TYPE_MSB:`BBR_TYPE_LSB] == `BBR_TYPE_64)
      atype = `BBR_TYPE_64;
    mask = 32'h00000000;
    if (en && io)
      // io: bits 31:8 always decode, 7:6 pick 64B..256B
      mask = {24'hFFFFFF, i_setup[`BBR_IO_SZ_MSB:`BBR_IO_SZ_LSB], 6'h00};
    else if (en)
      // memory: bit 31 is the enable so 2GB is the largest window
      mask = {i_setup[31:`BBR_MEM_BASE_LSB], 12'h000};
    bemask = {{8{i_be[3]}}, {8{i_be[2]}}, {8{i_be[1]}}, {8{i_be[0]}}};
    base_nxt = base_r & mask;
    if (i_we)
      base_nxt = (base_r & ~(mask & bemask)) | (i_wdata & mask & bemask);
    o_rd = 32'h00000000;
    // io mode keeps base bits 11:8 for decode but shows them as zero
    if (en)
      o_rd = (base_nxt & 32'hFFFFF0FF) |
        {28'h0000000, i_setup[`BBR_PREF_BIT], atype, io};
    fwd_nxt.hit = en && ((i_fwd_addr & mask) == base_r);
    fwd_nxt.addr = (i_xlat & mask) | (i_fwd_addr & ~mask);
  end

  always_ff @(posedge i_clk or posedge i_rst)
  begin
    if (i_rst)
    begin
      base_r <= `BBR_BASE_RST;
      fwd_r <= '0;
    end
    else
    begin
      base_r <= base_nxt;
      fwd_r <= fwd_nxt;
    end
  end

  assign o_fwd = fwd_r;

endmodule : bbr_win
